/* File: src/lcdcmd_top.sv */
/*
  Serial command interpreter and display memory access of a dot-matrix LCD
  row/column driver: a two-wire bus slave that takes commands and display
  bytes, stores or returns them through an auto-stepping pointer.
  Assumes SCL and SDA are oversampled by I_CLK (link clock about 160 ns),
  SDA is open drain with an external pull-up, and the display side reads
  memory on I_CLK.
*/
`timescale 1ns/1ns
`include "lcdcmd_defs.svh"
module lcdcmd_top (
  // Clock, reset and freeze.
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  // Two-wire bus and address strap.
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE_N,
  input wire logic I_ADDR_SELECT_STRAP,
  // Display-side memory read.
  input wire logic [1:0] I_DISP_BANK,
  input wire logic [5:0] I_DISP_COL,
  output logic [7:0] O_DISP_DATA,
  output logic O_DISP_VISIBLE,
  // Display configuration.
  output logic O_MIXED_MODE,
  output logic [1:0] O_DISPLAY_STATE,
  output logic [1:0] O_MUX_RATE,
  output logic [1:0] O_TOP_BANK,
  // Pointer state.
  output logic [1:0] O_ACCESS_ORDER,
  output logic [1:0] O_BANK_SELECT,
  output logic [5:0] O_COLUMN,
  output logic [3:0] O_SUBADDR
);

  logic [2:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic strap_s;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_done;
  logic sub_hit;
  logic addr_match;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic [7:0] ram_ddata;
  lcdcmd_pkg::lcdcmd_state_e state_q, state_d;
  lcdcmd_pkg::lcdcmd_phase_e phase_q, phase_d;
  lcdcmd_pkg::lcdcmd_cfg_s cfg_q, cfg_d;
  lcdcmd_pkg::lcdcmd_ptr_s ptr_q, ptr_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic rw_q, rw_d;
  logic drive_q, drive_d;
  logic acked_q, acked_d;
  logic [7:0] disp_q;
  logic vis_q;

  // Bus pins and strap cross into the clock domain.
  lcdcmd_sync #(.W(3)) u_sync (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_ce(I_CE),
    .i_async({I_SCL, I_SDA, I_ADDR_SELECT_STRAP}),
    .o_sync(pins_s)
  );

  assign scl_s = pins_s[2];
  assign sda_s = pins_s[1];
  assign strap_s = pins_s[0];

  lcdcmd_ram #(.BANKS(4), .COLS(40)) u_ram (
    .i_clk(I_CLK),
    .i_ce(I_CE),
    .i_we(ram_we),
    .i_wbank(ptr_q.bank),
    .i_wcol(ptr_q.col),
    .i_wdata(sh_q),
    .i_rbank(ptr_q.bank),
    .i_rcol(ptr_q.col),
    .o_rdata(ram_rdata),
    .i_dbank(I_DISP_BANK),
    .i_dcol(I_DISP_COL),
    .o_ddata(ram_ddata)
  );

  // Bus events seen from synchronised levels.
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign start_det = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_det = scl_s && scl_prev_q && !sda_prev_q && sda_s;
  assign byte_done = (state_q == lcdcmd_pkg::ST_RX) && scl_fall && (cnt_q == `LCDCMD_BYTE_BITS);
  assign sub_hit = cfg_q.mixed && (ptr_q.sub == `LCDCMD_OWN_SUB);
  assign addr_match = (sh_q[7:1] == {`LCDCMD_ADDR_HI, strap_s});
  assign ram_we = I_CE && byte_done && (phase_q == lcdcmd_pkg::PH_DATA) && sub_hit && !rw_q;

  // Steps the pointer by the selected access order; the device end steps the subaddress.
  function automatic lcdcmd_pkg::lcdcmd_ptr_s ptr_step(input lcdcmd_pkg::lcdcmd_ptr_s p);
    lcdcmd_pkg::lcdcmd_ptr_s n;
    logic col_inc;
    n = p;
    col_inc = 1'b1;
    case (p.order)
      lcdcmd_pkg::ORD_HALF:
      begin
        n.bank = {p.bank[1], ~p.bank[0]};
        col_inc = p.bank[0];
      end
      lcdcmd_pkg::ORD_FULL:
      begin
        n.bank = p.bank + 2'h1;
        col_inc = (p.bank == `LCDCMD_LAST_BANK);
      end
      default: col_inc = 1'b1;
    endcase
    if (col_inc)
    begin
      if (p.col >= `LCDCMD_LAST_COL)
      begin
        n.col = `LCDCMD_RST_COL;
        n.sub = p.sub + 4'h1;
      end
      else
        n.col = p.col + 6'h01;
    end
    return n;
  endfunction

  // Protocol, command decode and pointer next values.
  always_comb
  begin
    state_d = state_q;
    phase_d = phase_q;
    cfg_d = cfg_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    rw_d = rw_q;
    drive_d = drive_q;
    acked_d = acked_q;
    if (start_det)
    begin
      state_d = lcdcmd_pkg::ST_RX;
      phase_d = lcdcmd_pkg::PH_ADDR;
      cnt_d = 4'h0;
      drive_d = 1'b0;
    end
    else if (stop_det)
    begin
      state_d = lcdcmd_pkg::ST_IDLE;
      drive_d = 1'b0;
    end
    else
    begin
      case (state_q)
        lcdcmd_pkg::ST_RX:
        begin
          if (scl_rise && cnt_q != `LCDCMD_BYTE_BITS)
          begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            cnt_d = 4'h0;
            state_d = lcdcmd_pkg::ST_ACK;
            case (phase_q)
              lcdcmd_pkg::PH_ADDR:
              begin
                rw_d = sh_q[0];
                phase_d = lcdcmd_pkg::PH_CMD;
                if (!addr_match || (sh_q[0] && !cfg_q.mixed))
                  state_d = lcdcmd_pkg::ST_IDLE;
                else
                  drive_d = 1'b1;
              end
              lcdcmd_pkg::PH_CMD:
              begin
                drive_d = 1'b1;
                if (!sh_q[7])
                  phase_d = lcdcmd_pkg::PH_DATA;
                if (!sh_q[6])
                begin
                  if (sh_q[5:0] <= `LCDCMD_LAST_COL)
                    ptr_d.col = sh_q[5:0];
                end
                else if (!sh_q[5])
                begin
                  cfg_d.mixed = sh_q[4];
                  cfg_d.disp = sh_q[3:2];
                  cfg_d.mux = sh_q[1:0];
                end
                else if (!sh_q[4])
                  ptr_d.sub = sh_q[3:0];
                else if (sh_q[3:0] >= `LCDCMD_TOPBANK_MIN)
                  cfg_d.top_bank = sh_q[1:0];
                else
                begin
                  ptr_d.order = lcdcmd_pkg::lcdcmd_order_e'(sh_q[3:2]);
                  ptr_d.bank = sh_q[1:0];
                end
              end
              default:
              begin
                drive_d = sub_hit;
                if (cfg_q.mixed)
                  ptr_d = ptr_step(ptr_q);
              end
            endcase
          end
        end
        lcdcmd_pkg::ST_ACK:
        begin
          if (scl_fall)
          begin
            cnt_d = 4'h0;
            if (rw_q)
            begin
              state_d = lcdcmd_pkg::ST_TX;
              phase_d = lcdcmd_pkg::PH_DATA;
              // The pointer steps at load, so a foreign byte is loaded as all ones and never driven.
              sh_d = sub_hit ? ram_rdata : 8'hFF;
              drive_d = sub_hit && !ram_rdata[7];
              ptr_d = ptr_step(ptr_q);
            end
            else
            begin
              state_d = lcdcmd_pkg::ST_RX;
              drive_d = 1'b0;
            end
          end
        end
        lcdcmd_pkg::ST_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_q == `LCDCMD_TX_LAST)
            begin
              state_d = lcdcmd_pkg::ST_TXACK;
              drive_d = 1'b0;
              acked_d = 1'b0;
            end
            else
            begin
              sh_d = {sh_q[6:0], 1'b1};
              cnt_d = cnt_q + 4'h1;
              drive_d = !sh_q[6];
            end
          end
        end
        lcdcmd_pkg::ST_TXACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
            begin
              state_d = lcdcmd_pkg::ST_IDLE;
              drive_d = 1'b0;
            end
            else
              acked_d = 1'b1;
          end
          else if (scl_fall && acked_q)
          begin
            state_d = lcdcmd_pkg::ST_TX;
            cnt_d = 4'h0;
            sh_d = sub_hit ? ram_rdata : 8'hFF;
            drive_d = sub_hit && !ram_rdata[7];
            ptr_d = ptr_step(ptr_q);
          end
        end
        default: drive_d = 1'b0;
      endcase
    end
  end

  // Registers all protocol, configuration and display-read state.
  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      state_q <= lcdcmd_pkg::ST_IDLE;
      phase_q <= lcdcmd_pkg::PH_ADDR;
      cfg_q <= '{mixed: 1'b0, disp: `LCDCMD_RST_DISP, mux: `LCDCMD_RST_MUX, top_bank: `LCDCMD_RST_BANK};
      ptr_q <= '{order: lcdcmd_pkg::ORD_CHAR, bank: `LCDCMD_RST_BANK, col: `LCDCMD_RST_COL,
                 sub: `LCDCMD_RST_SUB};
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      drive_q <= 1'b0;
      acked_q <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      disp_q <= 8'h00;
      vis_q <= 1'b0;
    end
    else if (I_CE)
    begin
      state_q <= state_d;
      phase_q <= phase_d;
      cfg_q <= cfg_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      rw_q <= rw_d;
      drive_q <= drive_d;
      acked_q <= acked_d;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      disp_q <= ram_ddata;
      vis_q <= (I_DISP_COL >= `LCDCMD_FIRST_SHOWN) && (I_DISP_COL <= `LCDCMD_LAST_COL);
    end
  end

  // Outputs; SDA is open drain and only ever pulled low.
  assign O_SDA = 1'b0;
  assign O_SDA_OE_N = ~drive_q;
  assign O_DISP_DATA = disp_q;
  assign O_DISP_VISIBLE = vis_q;
  assign O_MIXED_MODE = cfg_q.mixed;
  assign O_DISPLAY_STATE = cfg_q.disp;
  assign O_MUX_RATE = cfg_q.mux;
  assign O_TOP_BANK = cfg_q.top_bank;
  assign O_ACCESS_ORDER = ptr_q.order;
  assign O_BANK_SELECT = ptr_q.bank;
  assign O_COLUMN = ptr_q.col;
  assign O_SUBADDR = ptr_q.sub;

  // Checks on the guarded behaviour.
  a_ram_col_range: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    ram_we |-> ptr_q.col <= `LCDCMD_LAST_COL) else $error("Memory write outside the column range.");
  a_store_sub_match: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    ram_we |-> ptr_q.sub == `LCDCMD_OWN_SUB) else $error("Memory written on subaddress mismatch.");
  a_row_mode_untouched: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    !cfg_q.mixed |-> !ram_we) else $error("Memory written in row mode.");
  a_row_no_transmit: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (state_q == lcdcmd_pkg::ST_TX) |-> cfg_q.mixed) else $error("Transmitting in row mode.");
  a_addr_miss_idle: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && byte_done && phase_q == lcdcmd_pkg::PH_ADDR && !addr_match && !start_det && !stop_det
    |=> state_q == lcdcmd_pkg::ST_IDLE && !drive_q) else $error("Foreign address not ignored.");
  a_cmd_acked: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && byte_done && phase_q == lcdcmd_pkg::PH_CMD && !start_det && !stop_det
    |=> drive_q && state_q == lcdcmd_pkg::ST_ACK) else $error("Command byte not acknowledged.");
  a_data_row_silent: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && byte_done && phase_q == lcdcmd_pkg::PH_DATA && !sub_hit |=> !drive_q)
    else $error("Foreign data byte acknowledged.");
  a_nack_release: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && state_q == lcdcmd_pkg::ST_TXACK && scl_rise && sda_s && !stop_det && !start_det
    |=> state_q == lcdcmd_pkg::ST_IDLE ##0 !drive_q[*2]) else $error("SDA held after master nack.");
  a_cont_to_data: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    I_CE && byte_done && phase_q == lcdcmd_pkg::PH_CMD && !sh_q[7] && !start_det && !stop_det
    |=> phase_q == lcdcmd_pkg::PH_DATA) else $error("Cleared flag did not end commands.");
  a_char_step: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    ram_we && ptr_q.order == lcdcmd_pkg::ORD_CHAR && ptr_q.col < `LCDCMD_LAST_COL && !start_det && !stop_det
    |=> ptr_q.col == $past(ptr_q.col) + 6'h01) else $error("Pointer did not step after a byte.");
  a_sub_wrap: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    ram_we && ptr_q.order == lcdcmd_pkg::ORD_CHAR && ptr_q.col == `LCDCMD_LAST_COL && !start_det && !stop_det
    |=> ptr_q.col == `LCDCMD_RST_COL) else $error("Pointer did not wrap at the last column.");
  c_data_store: cover property (@(posedge I_CLK) disable iff (!I_RST_N) ram_we);
  c_read_byte: cover property (@(posedge I_CLK) disable iff (!I_RST_N)
    state_q == lcdcmd_pkg::ST_TXACK && acked_q);
  c_top_bank: cover property (@(posedge I_CLK) disable iff (!I_RST_N) cfg_q.top_bank == `LCDCMD_LAST_BANK);
  c_half_order: cover property (@(posedge I_CLK) disable iff (!I_RST_N) ptr_q.order == lcdcmd_pkg::ORD_HALF);

endmodule

/* File: src/lcdcmd_defs.svh */
/*
  Shared constants of the LCD command interpreter: bus address, subaddress,
  column limits, bit counts and power-on values.
  Assumes it is included by its bare name from every file that needs it.
*/
`ifndef LCDCMD_DEFS_SVH
`define LCDCMD_DEFS_SVH

// Upper six bits of the 7-bit slave address; the lowest bit is the strap.
`define LCDCMD_ADDR_HI 6'h1E
// Fixed hardware subaddress of this device in mixed mode.
`define LCDCMD_OWN_SUB 4'h0
// Highest valid column address.
`define LCDCMD_LAST_COL 6'h27
// First column that reaches a column output.
`define LCDCMD_FIRST_SHOWN 6'h08
// Low nibble at or above which the access command means top bank.
`define LCDCMD_TOPBANK_MIN 4'hC
// Highest bank number.
`define LCDCMD_LAST_BANK 2'h3
// Bit count of a full byte and index of the last transmitted bit.
`define LCDCMD_BYTE_BITS 4'h8
`define LCDCMD_TX_LAST 4'h7
// Power-on values: blank display, 1:32 rate, row mode, bank 0, column 0.
`define LCDCMD_RST_DISP 2'h0
`define LCDCMD_RST_MUX 2'h0
`define LCDCMD_RST_BANK 2'h0
`define LCDCMD_RST_COL 6'h00
`define LCDCMD_RST_SUB 4'h0

`endif

/* File: src/lcdcmd_pkg.sv */
/*
  Types of the LCD command interpreter: protocol states, byte phases,
  access orders and the configuration and pointer carriers.
  Assumes nothing of its surroundings.
*/
package lcdcmd_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RX    = 3'b001,
    ST_ACK   = 3'b011,
    ST_TX    = 3'b010,
    ST_TXACK = 3'b110
  } lcdcmd_state_e;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_CMD  = 2'b01,
    PH_DATA = 2'b11
  } lcdcmd_phase_e;

  typedef enum logic [1:0] {
    ORD_CHAR = 2'b00,
    ORD_HALF = 2'b01,
    ORD_FULL = 2'b10
  } lcdcmd_order_e;

  typedef struct packed {
    logic mixed;
    logic [1:0] disp;
    logic [1:0] mux;
    logic [1:0] top_bank;
  } lcdcmd_cfg_s;

  typedef struct packed {
    lcdcmd_order_e order;
    logic [1:0] bank;
    logic [5:0] col;
    logic [3:0] sub;
  } lcdcmd_ptr_s;

endpackage

/* File: src/lcdcmd_sync.sv */
/*
  Two-stage synchroniser for pin inputs.
  Assumes the inputs are asynchronous to I_CLK; the bus idles high.
*/
`timescale 1ns/1ns
module lcdcmd_sync #(
  parameter int W = 3
) (
  // Clocking.
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      meta_q <= '1;
      sync_q <= '1;
    end
    else if (i_ce)
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

/* File: src/lcdcmd_ram.sv */
/*
  Display memory: banks of byte-wide columns held in flip-flops, one write
  port and two combinational read ports.
  Assumes write indices are in range; out-of-range reads return zero.
*/
`timescale 1ns/1ns
module lcdcmd_ram #(
  parameter int BANKS = 4,
  parameter int COLS = 40
) (
  // Clocking.
  input wire logic i_clk,
  input wire logic i_ce,
  // Write port.
  input wire logic i_we,
  input wire logic [1:0] i_wbank,
  input wire logic [5:0] i_wcol,
  input wire logic [7:0] i_wdata,
  // Serial-side read port.
  input wire logic [1:0] i_rbank,
  input wire logic [5:0] i_rcol,
  output logic [7:0] o_rdata,
  // Display-side read port.
  input wire logic [1:0] i_dbank,
  input wire logic [5:0] i_dcol,
  output logic [7:0] o_ddata
);

  logic [7:0] mem [BANKS*COLS];

  // One storage byte per bank and column.
  for (genvar e = 0; e < BANKS * COLS; e++)
  begin : g_entry
    always_ff @(posedge i_clk)
    begin
      if (i_ce && i_we && (32'(i_wbank) * COLS + 32'(i_wcol) == e))
        mem[e] <= i_wdata;
    end
  end

  // Reads pick the addressed byte by index.
  always_comb
  begin
    o_rdata = 8'h00;
    o_ddata = 8'h00;
    if (32'(i_rcol) < COLS)
      o_rdata = mem[32'(i_rbank) * COLS + 32'(i_rcol)];
    if (32'(i_dcol) < COLS)
      o_ddata = mem[32'(i_dbank) * COLS + 32'(i_dcol)];
  end

endmodule

/* File: verif/lcdcmd_master.sv */
/*
  Two-wire bus master model: start, stop, byte write and byte read.
  Assumes the bench resolves the open-drain data line with a pull-up and runs I_CLK at 100 MHz.
*/
`timescale 1ns/1ns
module lcdcmd_master (
  // Clock and resolved data line.
  input wire logic i_clk,
  input wire logic i_sda,
  // Bus outputs; a high data output releases the line.
  output logic o_scl,
  output logic o_sda
);
  // The bus idles released.
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Waits whole cycles, then steps just past the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Start or repeated start; leaves the clock low.
  task automatic start();
    tick(4);
    o_sda = 1'b1;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda = 1'b0;
    tick(8);
    o_scl = 1'b0;
  endtask

  // Stop from a low clock; the bus is left idle.
  task automatic stop();
    tick(4);
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b1;
    tick(8);
    o_sda = 1'b1;
    tick(8);
  endtask

  // One 160 ns pulse: data set late in the low phase, sampled mid high phase.
  task automatic bit_io(input logic v, output logic s);
    tick(6);
    o_sda = v;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    s = i_sda;
    tick(4);
    o_scl = 1'b0;
  endtask

  // Sends a byte MSB first; the ninth pulse returns the acknowledge.
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Receives a byte; the last one is not acknowledged, and the ninth-pulse line comes back.
  task automatic rd_byte(output logic [7:0] b, input logic last, output logic line);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, b[i]);
    end
    bit_io(last, line);
  endtask
endmodule

/* File: verif/lcdcmd_top_bench.sv */
/*
  Self-checking bench of the LCD command interpreter: commands, stepping writes, reads.
  Assumes the master model drives the bus and SDA has a pull-up.
*/
`timescale 1ns/1ns
`include "lcdcmd_defs.svh"
module lcdcmd_top_bench;
  logic clk, rst_n, strap, scl, sda_m, sda, oe_n, sda_o, vis, mixed, a;
  logic [1:0] dbank, disp, mux, top, order, bank, y;
  logic [5:0] dcol, col;
  logic [3:0] sub;
  logic [7:0] ddata, adr, d;
  logic [15:0] acks;
  logic [7:0] q[$];
  logic [7:0] mem[4][40];
  logic vld[4][40];
  lcdcmd_pkg::lcdcmd_ptr_s p, st, rs;
  int errors, checks_done;

  // Open-drain data line: low if either party pulls it.
  assign sda = sda_m & (oe_n | sda_o);

  lcdcmd_master i_m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));

  lcdcmd_top i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(1'b1), .I_SCL(scl), .I_SDA(sda), .O_SDA(sda_o),
    .O_SDA_OE_N(oe_n), .I_ADDR_SELECT_STRAP(strap), .I_DISP_BANK(dbank), .I_DISP_COL(dcol),
    .O_DISP_DATA(ddata), .O_DISP_VISIBLE(vis), .O_MIXED_MODE(mixed), .O_DISPLAY_STATE(disp),
    .O_MUX_RATE(mux), .O_TOP_BANK(top), .O_ACCESS_ORDER(order), .O_BANK_SELECT(bank),
    .O_COLUMN(col), .O_SUBADDR(sub));

  // The 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares one value and counts it.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("Counts: %0d checks, %0d errors", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One write transfer; bit i of e is the acknowledge expected for byte i.
  task automatic wr(input logic [7:0] b[$], input logic [15:0] e);
    logic k;
    i_m.start();
    foreach (b[i])
    begin
      i_m.wr_byte(b[i], k);
      chk(k, e[i]);
    end
    i_m.stop();
  endtask

  // Next pointer after one data byte, in the selected order.
  function automatic lcdcmd_pkg::lcdcmd_ptr_s nxt(input lcdcmd_pkg::lcdcmd_ptr_s x);
    logic step;
    step = 1'b1;
    if (x.order == lcdcmd_pkg::ORD_HALF)
    begin
      step = x.bank[0];
      x.bank[0] = ~x.bank[0];
    end
    else if (x.order == lcdcmd_pkg::ORD_FULL)
    begin
      step = (x.bank == `LCDCMD_LAST_BANK);
      x.bank = x.bank + 2'h1;
    end
    if (step && x.col == `LCDCMD_LAST_COL)
    begin
      x.col = 6'h00;
      x.sub = x.sub + 4'h1;
    end
    else if (step)
      x.col = x.col + 6'h01;
    return x;
  endfunction

  // Watchdog: the run needs about 10,000 cycles, so 40,000 cycles means a hang.
  initial
  begin
    #400000;
    errors++;
    finish_test();
  end

  // Main sequence.
  initial
  begin
    errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    dbank = 2'h0;
    dcol = 6'h00;
    vld = '{default: '{default: 1'b0}};
    void'($urandom(32'h722b812c));
    strap = 1'($urandom);
    adr = {`LCDCMD_ADDR_HI, strap, 1'b0};
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({mixed, disp, mux, top}, 7'h00);
    chk({order, bank, col, sub}, 14'h0000);
    $display("Test reset values done");
    wr('{adr ^ 8'h02, 8'h50}, 16'h0000);
    chk(mixed, 1'b0);
    i_m.start();
    i_m.wr_byte(adr | 8'h01, a);
    chk(a, 1'b0);
    i_m.stop();
    wr('{adr, 8'h27, 8'hA5}, 16'h0003);
    $display("Test addressing and row mode done");
    for (int i = 0; i < 4; i++)
    begin
      wr('{adr, 8'h50 | 8'(i << 2) | 8'((i + 1) % 4)}, 16'h0003);
      chk({mixed, disp, mux}, {1'b1, 2'(i), 2'((i + 1) % 4)});
    end
    for (int i = 0; i < 4; i++)
    begin
      y = 2'($urandom);
      wr('{adr, 8'hFC | 8'(i), 8'h70 | 8'((i % 3) << 2) | 8'(y)}, 16'h0007);
      chk({top, order, bank}, {2'(i), 2'(i % 3), y});
    end
    wr('{adr, 8'hA7, 8'hEF, 8'h28}, 16'h000F);
    chk({col, sub}, {6'h27, 4'hF});
    $display("Test commands done");
    for (int g = 0; g < 3; g++)
    begin
      st.order = lcdcmd_pkg::lcdcmd_order_e'(2'(g));
      st.bank = (g == 1) ? 2'h1 : 2'($urandom);
      st.col = (g == 1) ? 6'h27 : 6'h24 + 6'($urandom % 4);
      st.sub = (g == 1) ? 4'hF : `LCDCMD_OWN_SUB;
      if (g == 0)
        rs = st;
      p = st;
      q = '{adr, 8'hE0 | 8'(st.sub), 8'h80 | 8'(st.col), 8'h70 | 8'(g << 2) | 8'(st.bank)};
      acks = 16'h000F;
      for (int k = 4; k < 8; k++)
      begin
        d = 8'($urandom);
        q.push_back(d);
        acks[k] = (p.sub == `LCDCMD_OWN_SUB);
        if (acks[k])
        begin
          mem[p.bank][p.col] = d;
          vld[p.bank][p.col] = 1'b1;
        end
        p = nxt(p);
      end
      wr(q, acks);
      chk({order, bank, col, sub}, p);
    end
    for (int b = 0; b < 4; b++)
      for (int c = 0; c < 40; c++)
        if (vld[b][c])
        begin
          dbank = 2'(b);
          dcol = 6'(c);
          repeat (2) @(posedge clk);
          #1;
          chk(ddata, mem[b][c]);
          chk(vis, c >= 8);
        end
    $display("Test stepping writes done");
    wr('{adr, 8'hE0, 8'h80 | 8'(rs.col), 8'h70 | 8'(rs.bank)}, 16'h000F);
    p = rs;
    i_m.start();
    i_m.wr_byte(adr | 8'h01, a);
    chk(a, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      i_m.rd_byte(d, k == 2, a);
      chk(d, (p.sub == `LCDCMD_OWN_SUB) ? mem[p.bank][p.col] : 8'hFF);
      p = nxt(p);
    end
    chk(a, 1'b1);
    i_m.stop();
    chk(oe_n, 1'b1);
    chk({order, bank, col, sub}, p);
    $display("Test read done");
    finish_test();
  end
endmodule
